// ### include/otb_pkg.sv
// ----------------------------------------------------------------------
// Offset trim bank constants and types.
// ----------------------------------------------------------------------
package otb_pkg;

  // Bus and field widths.
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 16;
  localparam int TRIM_W   = 12;
  localparam int NUM_TRIM = 4;
  localparam int NUM_EV   = 4;

  // Byte offsets of the trim registers, each spanning two bytes.
  localparam logic [11:0] OFS_TRIM_C0_B = 12'h08C;
  localparam logic [11:0] OFS_TRIM_C1_A = 12'h08E;
  localparam logic [11:0] OFS_TRIM_C1_B = 12'h090;
  localparam logic [11:0] OFS_TRIM_C2_A = 12'h092;

  // Byte offsets of the event registers.
  localparam logic [11:0] OFS_EV_STATUS = 12'h0A0;
  localparam logic [11:0] OFS_EV_CLEAR  = 12'h0A2;
  localparam logic [11:0] OFS_EV_ENABLE = 12'h0A4;

  // Index of each trim register in the bank.
  localparam logic [1:0] IDX_C0_B = 2'h0;
  localparam logic [1:0] IDX_C1_A = 2'h1;
  localparam logic [1:0] IDX_C1_B = 2'h2;
  localparam logic [1:0] IDX_C2_A = 2'h3;

  // Reset values.
  localparam logic [15:0] TRIM_RST   = 16'h0000;
  localparam logic [3:0]  EV_EN_RST  = 4'h0;
  localparam logic [3:0]  EV_ST_RST  = 4'h0;

  // Event bit positions in status, clear and enable.
  localparam int EV_WR_FG = 0;
  localparam int EV_WR_BG = 1;
  localparam int EV_RD_FG = 2;
  localparam int EV_RD_BG = 3;

  // Bank sequencing: factory load first, then normal operation.
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } otb_state_t;

  // Trim register decode: bit 2 is hit, bits 1:0 the index.
  function automatic logic [2:0] otb_decode(input logic [11:0] addr);
    logic [2:0] res;
    res = 3'h0;
    case (addr)
      OFS_TRIM_C0_B: res = {1'b1, IDX_C0_B};
      OFS_TRIM_C1_A: res = {1'b1, IDX_C1_A};
      OFS_TRIM_C1_B: res = {1'b1, IDX_C1_B};
      OFS_TRIM_C2_A: res = {1'b1, IDX_C2_A};
      default:       res = 3'h0;
    endcase
    return res;
  endfunction : otb_decode

endpackage : otb_pkg

// ### logic/otb_trim_reg.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// One 16-bit trim register with a factory load.
// ----------------------------------------------------------------------
module otb_trim_reg #(
  parameter int DATA_W = 16,
  parameter int TRIM_W = 12
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              loadFactory,
  input  wire logic [TRIM_W-1:0] factoryTrim,
  input  wire logic              writeEn,
  input  wire logic [DATA_W-1:0] writeData,
  output logic      [DATA_W-1:0] value
);

  // The factory value cannot be taken under reset, since an async reset
  // may only load a constant; it is loaded on the first clocked cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      value <= otb_pkg::TRIM_RST;
    end else if (loadFactory) begin
      value[TRIM_W-1:0] <= factoryTrim;
    end else if (writeEn) begin
      value <= writeData;
    end
  end

endmodule : otb_trim_reg

// ### logic/otb_offset_trim_bank.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - Each trim holds a 12-bit unsigned value in 11:0; 15:12 are reserved.
// - After reset each trim holds its factory value, readable and writable.
// - The register at 0x08C trims core 0 while it converts input B.
// - The register at 0x08E trims core 1 while it converts input A.
// - The register at 0x090 trims core 1 while it converts input B.
// - The register at 0x092 trims core 2 while it converts input A.
module otb_offset_trim_bank (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [11:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdData,
  input  wire logic [11:0] factoryTrimCore0InputB,
  input  wire logic [11:0] factoryTrimCore1InputA,
  input  wire logic [11:0] factoryTrimCore1InputB,
  input  wire logic [11:0] factoryTrimCore2InputA,
  input  wire logic        foregroundCalBusy,
  input  wire logic        offsetCalibrationEnable,
  input  wire logic        backgroundCalibrationEnable,
  input  wire logic        backgroundOffsetCalibrationEnable,
  input  wire logic        foregroundCompletionFlag,
  input  wire logic        calibrationStoppedFlag,
  input  wire logic        core1SamplesInputB,
  output logic      [11:0] core0InputBTrim,
  output logic      [11:0] core1AppliedTrim,
  output logic      [11:0] core2InputATrim,
  output logic             trimValid,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  otb_pkg::otb_state_t state;
  logic [15:0] trimReg [otb_pkg::NUM_TRIM];
  logic [11:0] factoryTrim [otb_pkg::NUM_TRIM];
  logic [2:0]  wrDec;
  logic [2:0]  rdDec;
  logic        loadFactory;
  logic [3:0]  evStatus;
  logic [3:0]  evEnable;
  logic [3:0]  evSet;
  logic [3:0]  evClear;
  logic        bgOffsetOn;
  logic        fgOffsetOnly;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------

  // The same decode serves both strobes; an odd byte address misses.
  assign wrDec = otb_pkg::otb_decode(regAddr);
  assign rdDec = otb_pkg::otb_decode(regAddr);

  assign factoryTrim[otb_pkg::IDX_C0_B] = factoryTrimCore0InputB;
  assign factoryTrim[otb_pkg::IDX_C1_A] = factoryTrimCore1InputA;
  assign factoryTrim[otb_pkg::IDX_C1_B] = factoryTrimCore1InputB;
  assign factoryTrim[otb_pkg::IDX_C2_A] = factoryTrimCore2InputA;

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------

  // One load cycle after reset release picks up the factory trims.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= otb_pkg::ST_LOAD;
    end else begin
      case (state)
        otb_pkg::ST_LOAD: state <= otb_pkg::ST_RUN;
        otb_pkg::ST_RUN:  state <= otb_pkg::ST_RUN;
        default:          state <= otb_pkg::ST_LOAD;
      endcase
    end
  end

  assign loadFactory = (state == otb_pkg::ST_LOAD);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trimValid <= 1'b0;
    end else begin
      trimValid <= (state == otb_pkg::ST_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // Trim storage
  // ----------------------------------------------------------------------

  // A write in the load cycle loses to the factory value; software
  // should wait for trimValid before touching the bank.
  for (genvar i = 0; i < otb_pkg::NUM_TRIM; i++) begin : g_trim
    otb_trim_reg #(
      .DATA_W (otb_pkg::DATA_W),
      .TRIM_W (otb_pkg::TRIM_W)
    ) u_trim (
      .mclk        (mclk),
      .arst_n      (arst_n),
      .loadFactory (loadFactory),
      .factoryTrim (factoryTrim[i]),
      .writeEn     (regWrite && wrDec[2] && (wrDec[1:0] == 2'(i))),
      .writeData   (regWrData),
      .value       (trimReg[i])
    );
  end

  // ----------------------------------------------------------------------
  // Applied trims
  // ----------------------------------------------------------------------

  // Only the 12-bit field is applied; reserved bits stay in the bank.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core0InputBTrim <= 12'h000;
    end else begin
      core0InputBTrim <= trimReg[otb_pkg::IDX_C0_B][11:0];
    end
  end

  // Core 1 swaps trims with its input so no glitch reaches the core.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core1AppliedTrim <= 12'h000;
    end else if (core1SamplesInputB) begin
      core1AppliedTrim <= trimReg[otb_pkg::IDX_C1_B][11:0];
    end else begin
      core1AppliedTrim <= trimReg[otb_pkg::IDX_C1_A][11:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core2InputATrim <= 12'h000;
    end else begin
      core2InputATrim <= trimReg[otb_pkg::IDX_C2_A][11:0];
    end
  end

  // ----------------------------------------------------------------------
  // Access hazard events
  // ----------------------------------------------------------------------

  // Accesses that break the calibration interlocks are not blocked, since
  // software owns that discipline; they are flagged so firmware can see
  // that a trim may have been corrupted or read while unsettled.
  assign bgOffsetOn   = backgroundCalibrationEnable &&
                        backgroundOffsetCalibrationEnable;
  assign fgOffsetOnly = offsetCalibrationEnable &&
                        !backgroundOffsetCalibrationEnable;

  always_comb begin
    evSet = 4'h0;
    evSet[otb_pkg::EV_WR_FG] = regWrite && wrDec[2] &&
                               foregroundCalBusy;
    evSet[otb_pkg::EV_WR_BG] = regWrite && wrDec[2] && bgOffsetOn;
    evSet[otb_pkg::EV_RD_FG] = regRead && rdDec[2] && fgOffsetOnly &&
                               !foregroundCompletionFlag;
    evSet[otb_pkg::EV_RD_BG] = regRead && rdDec[2] && bgOffsetOn &&
                               !calibrationStoppedFlag;
  end

  assign evClear = (regWrite && regAddr == otb_pkg::OFS_EV_CLEAR) ?
                   regWrData[3:0] : 4'h0;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evStatus <= otb_pkg::EV_ST_RST;
    end else begin
      evStatus <= (evStatus & ~evClear) | evSet;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evEnable <= otb_pkg::EV_EN_RST;
    end else if (regWrite && regAddr == otb_pkg::OFS_EV_ENABLE) begin
      evEnable <= regWrData[3:0];
    end
  end

  assign irq = |(evStatus & evEnable);

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------

  // Data stands for exactly one cycle after the strobe, zero otherwise;
  // unmapped addresses and the clear register read as zero.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 16'h0000;
    end else if (!regRead) begin
      regRdData <= 16'h0000;
    end else if (rdDec[2]) begin
      regRdData <= trimReg[rdDec[1:0]];
    end else if (regAddr == otb_pkg::OFS_EV_STATUS) begin
      regRdData <= {12'h000, evStatus};
    end else if (regAddr == otb_pkg::OFS_EV_ENABLE) begin
      regRdData <= {12'h000, evEnable};
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_write_readback;
    (regWrite && regAddr == otb_pkg::OFS_TRIM_C1_A && trimValid)
      ##1 (regRead && regAddr == otb_pkg::OFS_TRIM_C1_A && !regWrite)
      |=> regRdData == $past(regWrData, 2);
  endproperty
  a_write_readback: assert property (p_write_readback)
    else $error("Trim readback differs from written word.");

  property p_factory_load;
    $fell(loadFactory) |-> trimReg[otb_pkg::IDX_C2_A] ==
                           {4'h0, $past(factoryTrimCore2InputA)};
  endproperty
  a_factory_load: assert property (p_factory_load)
    else $error("Factory trim not loaded after reset.");

  property p_core0_trim;
    ($stable(trimReg[otb_pkg::IDX_C0_B]))[*2]
      |-> core0InputBTrim == trimReg[otb_pkg::IDX_C0_B][11:0];
  endproperty
  a_core0_trim: assert property (p_core0_trim)
    else $error("Core 0 input B trim does not follow its register.");

  property p_core1_a;
    !core1SamplesInputB |=> core1AppliedTrim ==
                            $past(trimReg[otb_pkg::IDX_C1_A][11:0]);
  endproperty
  a_core1_a: assert property (p_core1_a)
    else $error("Core 1 input A trim wrong.");

  property p_core1_b;
    core1SamplesInputB |=> core1AppliedTrim ==
                           $past(trimReg[otb_pkg::IDX_C1_B][11:0]);
  endproperty
  a_core1_b: assert property (p_core1_b)
    else $error("Core 1 input B trim wrong.");

  property p_core2_trim;
    (regWrite && regAddr == otb_pkg::OFS_TRIM_C2_A && trimValid)
      |-> ##2 core2InputATrim == $past(regWrData[11:0], 2);
  endproperty
  a_core2_trim: assert property (p_core2_trim)
    else $error("Core 2 input A trim not applied two cycles on.");

  property p_reserved_no_effect;
    (regWrite && regAddr == otb_pkg::OFS_TRIM_C0_B && trimValid &&
     regWrData[11:0] == trimReg[otb_pkg::IDX_C0_B][11:0])
      |-> ##2 $stable(core0InputBTrim);
  endproperty
  a_reserved_no_effect: assert property (p_reserved_no_effect)
    else $error("Reserved bits changed the applied trim.");

  property p_wr_fg_flag;
    (regWrite && wrDec[2] && foregroundCalBusy) |=>
      evStatus[otb_pkg::EV_WR_FG] ##1
      (evStatus[otb_pkg::EV_WR_FG] || $past(evClear[otb_pkg::EV_WR_FG]));
  endproperty
  a_wr_fg_flag: assert property (p_wr_fg_flag)
    else $error("Write during foreground run not flagged.");

  property p_rd_bg_flag;
    (regRead && rdDec[2] && bgOffsetOn && !calibrationStoppedFlag &&
     evEnable[otb_pkg::EV_RD_BG]) |=> irq;
  endproperty
  a_rd_bg_flag: assert property (p_rd_bg_flag)
    else $error("Unsafe read did not raise the interrupt.");

  property p_rd_idle_zero;
    !regRead |=> regRdData == 16'h0000;
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("Read data stands beyond its cycle.");

  property p_wr_bg_flag;
    (regWrite && wrDec[2] && bgOffsetOn) |=> evStatus[otb_pkg::EV_WR_BG];
  endproperty
  a_wr_bg_flag: assert property (p_wr_bg_flag)
    else $error("Write during background offset run not flagged.");

  c_factory: cover property (loadFactory ##1 trimValid);
  c_swap: cover property (core1SamplesInputB ##1 !core1SamplesInputB);
  c_irq: cover property ($rose(irq));
  c_readback: cover property (regWrite ##1 regRead);

endmodule : otb_offset_trim_bank

// ### sim/offset_trim_register_bank_tb.sv
`timescale 1ns/10ps
module offset_trim_register_bank_tb;

  // ----------------------------------------------------------------------
  // Signals, expectation queue and register model.
  // ----------------------------------------------------------------------
  logic        mclk;
  logic        arst_n;
  logic [11:0] regAddr;
  logic [15:0] regWrData;
  logic        regWrite;
  logic        regRead;
  logic [15:0] regRdData;
  logic [11:0] fac [4];
  logic [5:0]  cal;
  logic        core1SamplesInputB;
  logic [11:0] core0InputBTrim;
  logic [11:0] core1AppliedTrim;
  logic [11:0] core2InputATrim;
  logic        trimValid;
  logic        irq;
  logic        rdPend;
  logic [15:0] model [4];
  logic [11:0] ofs [4];
  logic [15:0] expQ [$];
  logic [15:0] d;
  logic [15:0] evBit;
  int          n_errors;
  int          cmp_count;
  int          cycles;

  // Calibration levels: bit 0 busy, 1 offset, 2 bg, 3 bg offset, 4 done,
  // 5 stopped. Idle keeps both flags up so that no access is flagged.
  localparam logic [5:0] CAL_IDLE = 6'h30;
  localparam logic [5:0] EV_CFG [4] = '{6'h31, 6'h3C, 6'h22, 6'h1C};
  localparam logic [3:0] EV_READ = 4'hC;

  otb_offset_trim_bank dut (
    .mclk                              (mclk),
    .arst_n                            (arst_n),
    .regAddr                           (regAddr),
    .regWrData                         (regWrData),
    .regWrite                          (regWrite),
    .regRead                           (regRead),
    .regRdData                         (regRdData),
    .factoryTrimCore0InputB            (fac[0]),
    .factoryTrimCore1InputA            (fac[1]),
    .factoryTrimCore1InputB            (fac[2]),
    .factoryTrimCore2InputA            (fac[3]),
    .foregroundCalBusy                 (cal[0]),
    .offsetCalibrationEnable           (cal[1]),
    .backgroundCalibrationEnable       (cal[2]),
    .backgroundOffsetCalibrationEnable (cal[3]),
    .foregroundCompletionFlag          (cal[4]),
    .calibrationStoppedFlag            (cal[5]),
    .core1SamplesInputB                (core1SamplesInputB),
    .core0InputBTrim                   (core0InputBTrim),
    .core1AppliedTrim                  (core1AppliedTrim),
    .core2InputATrim                   (core2InputATrim),
    .trimValid                         (trimValid),
    .irq                               (irq)
  );

  // Clock of 40 ns and a cycle ceiling that cuts a hang short.
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      $display("BAD %0t run did not finish in time", $time);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Compare and bus tasks.
  // ----------------------------------------------------------------------
  task automatic chkRead(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask : chkRead

  task automatic chkOut(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask : chkOut

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= v;
    regWrite  <= 1'b1;
    @(posedge mclk);
    regWrite  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge mclk);
    regRead <= 1'b0;
  endtask : rd

  // Two edges cover the register latency plus the output register.
  task automatic chkApplied();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chkOut({4'h0, core0InputBTrim}, {4'h0, model[0][11:0]});
    chkOut({4'h0, core1AppliedTrim},
           {4'h0, model[core1SamplesInputB ? 2 : 1][11:0]});
    chkOut({4'h0, core2InputATrim}, {4'h0, model[3][11:0]});
  endtask : chkApplied

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Read data stand only in the cycle after the strobe, so look there.
  always @(posedge mclk) rdPend <= regRead;

  always @(negedge mclk) begin
    if (rdPend && expQ.size() > 0) begin
      chkRead(regRdData, expQ.pop_front());
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    regAddr = 12'h000;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    cal = CAL_IDLE;
    core1SamplesInputB = 1'b0;
    rdPend = 1'b0;
    ofs = '{otb_pkg::OFS_TRIM_C0_B, otb_pkg::OFS_TRIM_C1_A,
            otb_pkg::OFS_TRIM_C1_B, otb_pkg::OFS_TRIM_C2_A};
    void'($urandom(68863));
    for (int i = 0; i < 4; i++) begin
      fac[i] = 12'($urandom);
      model[i] = {4'h0, fac[i]};
    end
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chkOut({15'h0000, trimValid}, 16'h0001);
    chkApplied();
    for (int i = 0; i < 4; i++) rd(ofs[i], model[i]);
    $display("factory load test done");

    // Full 16-bit words, reserved bits included, under both selects.
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        d = 16'($urandom);
        wr(ofs[i], d);
        model[i] = d;
        rd(ofs[i], d);
      end
      chkApplied();
      @(posedge mclk);
      core1SamplesInputB <= ~core1SamplesInputB;
      chkApplied();
    end
    // Write then read with no gap, then a write moving only reserved bits.
    @(posedge mclk);
    d = 16'($urandom);
    regAddr   <= ofs[1];
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge mclk);
    regWrite  <= 1'b0;
    regRead   <= 1'b1;
    expQ.push_back(d);
    model[1] = d;
    @(posedge mclk);
    regRead   <= 1'b0;
    d = {~model[0][15:12], model[0][11:0]};
    wr(ofs[0], d);
    model[0] = d;
    rd(ofs[0], d);
    chkApplied();
    $display("read write test done");

    // Odd and unmapped places take nothing; status is read-only.
    wr(otb_pkg::OFS_TRIM_C0_B + 12'h001, 16'hFFFF);
    rd(otb_pkg::OFS_TRIM_C0_B + 12'h001, 16'h0000);
    rd(otb_pkg::OFS_TRIM_C0_B, model[0]);
    wr(otb_pkg::OFS_EV_STATUS, 16'h000F);
    rd(otb_pkg::OFS_EV_STATUS, 16'h0000);
    rd(otb_pkg::OFS_EV_CLEAR, 16'h0000);
    rd(12'hFFE, 16'h0000);
    $display("refused access test done");

    // Each forbidden access sets its own sticky bit, masked then raised.
    for (int k = 0; k < 4; k++) begin
      evBit = 16'h0001 << k;
      wr(otb_pkg::OFS_EV_ENABLE, 16'h0000);
      @(posedge mclk);
      cal <= EV_CFG[k];
      if (EV_READ[k]) begin
        rd(ofs[k], model[k]);
      end else begin
        d = 16'($urandom);
        wr(ofs[k], d);
        model[k] = d;
      end
      @(posedge mclk);
      cal <= CAL_IDLE;
      rd(otb_pkg::OFS_EV_STATUS, evBit);
      @(negedge mclk);
      chkOut({15'h0000, irq}, 16'h0000);
      wr(otb_pkg::OFS_EV_ENABLE, evBit);
      @(negedge mclk);
      chkOut({15'h0000, irq}, 16'h0001);
      rd(otb_pkg::OFS_EV_ENABLE, evBit);
      wr(otb_pkg::OFS_EV_CLEAR, evBit);
      @(negedge mclk);
      chkOut({15'h0000, irq}, 16'h0000);
      rd(otb_pkg::OFS_EV_STATUS, 16'h0000);
      rd(ofs[k], model[k]);
    end
    // An unsafe read whose event is already enabled raises irq at once.
    wr(otb_pkg::OFS_EV_ENABLE, 16'h000F);
    @(posedge mclk);
    cal <= EV_CFG[3];
    rd(ofs[3], model[3]);
    @(posedge mclk);
    cal <= CAL_IDLE;
    @(negedge mclk);
    chkOut({15'h0000, irq}, 16'h0001);
    wr(otb_pkg::OFS_EV_CLEAR, 16'h000F);
    rd(otb_pkg::OFS_EV_STATUS, 16'h0000);
    $display("event test done");
    repeat (3) @(posedge mclk);
    end_of_test();
  end

endmodule : offset_trim_register_bank_tb
